// ===== hw/psc_pkg.sv
package psc_pkg;
  // ==========================================================
  // management register indices
  // ==========================================================
  localparam logic [4:0] CONTROL_REG_INDEX = 5'h00;
  localparam logic [4:0] STATUS_REG_INDEX = 5'h01;
  localparam logic [4:0] ID_HIGH_REG_INDEX = 5'h02;
  localparam logic [4:0] ID_LOW_REG_INDEX = 5'h03;
  localparam logic [4:0] ADVERT_REG_INDEX = 5'h04;
  localparam logic [4:0] PARTNER_REG_INDEX = 5'h05;
  localparam logic [4:0] EXPANSION_REG_INDEX = 5'h06;
  localparam logic [4:0] CFG_IRQ_REG_INDEX = 5'h11;
  localparam logic [4:0] IRQ_EN_REG_INDEX = 5'h12;
  localparam logic [4:0] FAST_CTL_REG_INDEX = 5'h13;
  localparam logic [4:0] MODE_CTL_REG_INDEX = 5'h14;
  // ==========================================================
  // field positions and reset values
  // ==========================================================
  localparam int ADV_FIELD_LSB = 5; // advert bits 8:5
  localparam int FAST_NRZI_BIT = 7;
  localparam int FAST_4B5B_BIT = 6;
  localparam int FAST_SCR_DIS_BIT = 0;
  localparam logic [3:0] ADV_DEFAULT = 4'hF; // fixed advert default
  localparam logic [4:0] ADV_SELECTOR = 5'h01; // selector field
  localparam logic [15:0] STATUS_VALUE = 16'h7800; // abilities
  localparam logic [15:0] ID_HIGH_VALUE = 16'h1234; // arbitrary value
  localparam logic [15:0] ID_LOW_VALUE = 16'h5670; // arbitrary value
  localparam logic [15:0] VENDOR_RESET = 16'h0000;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20; // ones before a frame
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  // ==========================================================
  // types
  // ==========================================================
  typedef struct packed {
    logic anEnable; // function strap 0
    logic nrziEnable; // function strap 1
    logic code4b5bEnable; // function strap 2
    logic scramblerDisable; // function strap 3
    logic speed100; // function strap 4
    logic fastAdvert; // fast advertisement strap
    logic slowAdvert; // slow advertisement strap
    logic fullDuplex; // full-duplex strap
    logic [4:0] phyAddr; // address straps, shared with leds
  } psc_strap_s;

  typedef struct packed {
    logic softReset; // 15
    logic loopback; // 14
    logic speed100; // 13
    logic anEnable; // 12
    logic powerDown; // 11
    logic isolate; // 10
    logic anRestart; // 9
    logic duplex; // 8
    logic colTest; // 7
    logic [6:0] rsvd; // 6:0 read zero
  } psc_ctrl_s;

  typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} psc_mdio_e;
endpackage : psc_pkg

// ===== hw/psc_strap_regs.sv
`timescale 1ns/1ps
module psc_strap_regs
  import psc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire psc_strap_s straps, // strap levels
  input wire logic mdc, // management clock, sampled
  input wire logic mdioIn, // management data in
  output logic mdioOut, // management data out
  output logic mdioOeN, // low while driving mdio
  input wire logic [4:0] ledIn, // led status, active high
  output logic [4:0] ledOut, // led pins after polarity
  input wire logic anSpeed100, // negotiated speed
  input wire logic anFullDuplex, // negotiated duplex
  output logic speed100, // effective speed
  output logic fullDuplex, // effective duplex
  output logic loopback, // loopback mode
  output logic miiIsolate, // float mii outputs, ignore tx
  output psc_ctrl_s ctrlBits // whole control register
);
  // ==========================================================
  // state
  // ==========================================================
  psc_ctrl_s ctrl_q; // control register
  logic [15:0] advert_q; // advertisement register
  logic [15:0] cfgIrq_q; // vendor config and irq status
  logic [15:0] irqEn_q; // vendor irq enable
  logic [15:0] fastCtl_q; // vendor 100 mb/s control
  logic [15:0] modeCtl_q; // vendor mode control
  logic [4:0] phyAddr_q; // latched phy address
  logic [4:0] ledPol_q; // one inverts the led
  logic loadPend_q; // first cycle after reset release
  logic load; // reload straps and defaults
  logic anEff; // autoneg in force at load
  logic mdcPrev_q; // mdc last cycle
  logic mdcRise; // mdc rising edge
  psc_mdio_e state_q; // frame state
  logic [5:0] preCnt_q; // preamble ones
  logic [4:0] bitCnt_q; // bit within field
  logic [11:0] hdr_q; // header shift
  logic [15:0] sh_q; // data shift
  logic isRead_q; // current frame reads
  logic [4:0] regAddr_q; // register of frame
  logic wrEn_q; // one-cycle write pulse
  logic [15:0] wrData_q; // write data
  logic [4:0] wrAddr_q; // write register
  logic [12:0] hdrFull; // header incl. last bit
  logic [15:0] rdData; // read mux

  // advert bits 8:5 from straps
  function automatic logic [3:0] advFromStraps(input psc_strap_s s);
    advFromStraps = {s.fastAdvert & s.fullDuplex, s.fastAdvert,
                     s.slowAdvert & s.fullDuplex, s.slowAdvert};
  endfunction : advFromStraps

  // ==========================================================
  // load control
  // ==========================================================
  // load straps once after reset release and on soft reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loadPend_q <= 1'b1;
    end else begin
      loadPend_q <= 1'b0;
    end
  end
  assign load = loadPend_q | ctrl_q.softReset;
  // ctrl_q.anEnable is 1 from reset, so power-up uses the strap
  assign anEff = straps.anEnable & ctrl_q.anEnable;

  // ==========================================================
  // control register
  // ==========================================================
  // reload, software write, self-clearing bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      ctrl_q.speed100 <= 1'b1;
      ctrl_q.anEnable <= 1'b1;
    end else if (load) begin
      ctrl_q <= '0;
      ctrl_q.speed100 <= straps.speed100;
      ctrl_q.anEnable <= straps.anEnable;
      ctrl_q.isolate <= (straps.phyAddr == 5'h00);
      ctrl_q.duplex <= straps.anEnable ? 1'b0 : straps.fullDuplex;
    end else if (wrEn_q && wrAddr_q == CONTROL_REG_INDEX) begin
      ctrl_q <= psc_ctrl_s'({wrData_q[15:7], 7'h00});
    end else begin
      ctrl_q.anRestart <= 1'b0; // restart is a pulse
    end
  end

  // ==========================================================
  // advertisement and vendor registers
  // ==========================================================
  // advertisement: strap derived or fixed default
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      advert_q <= {7'h00, ADV_DEFAULT, ADV_SELECTOR};
    end else if (load) begin
      advert_q <= {7'h00, anEff ? advFromStraps(straps)
                                : ADV_DEFAULT, ADV_SELECTOR};
    end else if (wrEn_q && wrAddr_q == ADVERT_REG_INDEX) begin
      advert_q <= {wrData_q[15:5], ADV_SELECTOR};
    end
  end

  // vendor registers, plain storage with strap seeded bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgIrq_q <= VENDOR_RESET;
      irqEn_q <= VENDOR_RESET;
      fastCtl_q <= VENDOR_RESET;
      modeCtl_q <= VENDOR_RESET;
    end else if (load) begin
      cfgIrq_q <= VENDOR_RESET;
      irqEn_q <= VENDOR_RESET;
      modeCtl_q <= VENDOR_RESET;
      fastCtl_q <= VENDOR_RESET;
      fastCtl_q[FAST_NRZI_BIT] <= straps.nrziEnable;
      fastCtl_q[FAST_4B5B_BIT] <= straps.code4b5bEnable;
      fastCtl_q[FAST_SCR_DIS_BIT] <= straps.scramblerDisable;
    end else if (wrEn_q) begin
      // vendor write decode
      if (wrAddr_q == CFG_IRQ_REG_INDEX) begin
        cfgIrq_q <= wrData_q;
      end else if (wrAddr_q == IRQ_EN_REG_INDEX) begin
        irqEn_q <= wrData_q;
      end else if (wrAddr_q == FAST_CTL_REG_INDEX) begin
        fastCtl_q <= wrData_q;
      end else if (wrAddr_q == MODE_CTL_REG_INDEX) begin
        modeCtl_q <= wrData_q;
      end
    end
  end

  // ==========================================================
  // address and led straps
  // ==========================================================
  // latch address and led polarity at load
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phyAddr_q <= 5'h00;
      ledPol_q <= 5'h00;
    end else if (load) begin
      phyAddr_q <= straps.phyAddr;
      ledPol_q <= straps.phyAddr;
    end
  end

  // led drivers: high strap gives active low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ledOut <= 5'h00;
    end else begin
      ledOut <= ledIn ^ ledPol_q;
    end
  end

  // ==========================================================
  // operating mode outputs
  // ==========================================================
  // speed bit ignored while autoneg runs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed100 <= 1'b1;
      fullDuplex <= 1'b0;
      loopback <= 1'b0;
      miiIsolate <= 1'b0;
      ctrlBits <= '0;
    end else begin
      speed100 <= ctrl_q.anEnable ? anSpeed100 : ctrl_q.speed100;
      fullDuplex <= ctrl_q.anEnable ? anFullDuplex : ctrl_q.duplex;
      loopback <= ctrl_q.loopback;
      miiIsolate <= ctrl_q.isolate;
      ctrlBits <= ctrl_q;
    end
  end

  // ==========================================================
  // read mux
  // ==========================================================
  // register decode, unmapped reads as zero
  always_comb begin
    rdData = 16'h0000;
    if (regAddr_q == CONTROL_REG_INDEX) begin
      rdData = ctrl_q;
    end else if (regAddr_q == STATUS_REG_INDEX) begin
      rdData = STATUS_VALUE;
    end else if (regAddr_q == ID_HIGH_REG_INDEX) begin
      rdData = ID_HIGH_VALUE;
    end else if (regAddr_q == ID_LOW_REG_INDEX) begin
      rdData = ID_LOW_VALUE;
    end else if (regAddr_q == ADVERT_REG_INDEX) begin
      rdData = advert_q;
    end else if (regAddr_q == PARTNER_REG_INDEX) begin
      rdData = 16'h0000; // no partner data in this block
    end else if (regAddr_q == EXPANSION_REG_INDEX) begin
      rdData = 16'h0000;
    end else if (regAddr_q == CFG_IRQ_REG_INDEX) begin
      rdData = cfgIrq_q;
    end else if (regAddr_q == IRQ_EN_REG_INDEX) begin
      rdData = irqEn_q;
    end else if (regAddr_q == FAST_CTL_REG_INDEX) begin
      rdData = fastCtl_q;
    end else if (regAddr_q == MODE_CTL_REG_INDEX) begin
      rdData = modeCtl_q;
    end
  end

  // ==========================================================
  // management frame engine
  // ==========================================================
  assign mdcRise = mdc & ~mdcPrev_q;
  assign hdrFull = {hdr_q, mdioIn};

  // mdc edge detector
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mdcPrev_q <= 1'b1; // mdc idles high, no false rise after reset
    end else begin
      mdcPrev_q <= mdc;
    end
  end

  // frame state machine, bits taken on mdc rise; isolate
  // leaves it running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_PRE;
      preCnt_q <= 6'h00;
      bitCnt_q <= 5'h00;
      hdr_q <= 12'h000;
      sh_q <= 16'h0000;
      isRead_q <= 1'b0;
      regAddr_q <= 5'h00;
      wrEn_q <= 1'b0;
      wrData_q <= 16'h0000;
      wrAddr_q <= 5'h00;
      mdioOut <= 1'b1;
      mdioOeN <= 1'b1;
    end else begin
      wrEn_q <= 1'b0;
      if (mdcRise) begin
        case (state_q)
          ST_PRE: begin
            // count ones, a zero after enough starts a frame
            if (mdioIn) begin
              if (preCnt_q != PREAMBLE_LEN) begin
                preCnt_q <= preCnt_q + 6'h01;
              end
            end else begin
              if (preCnt_q == PREAMBLE_LEN) begin
                state_q <= ST_HDR;
                bitCnt_q <= 5'h00;
              end
              preCnt_q <= 6'h00;
            end
          end
          ST_HDR: begin
            // start bit, opcode, phy and register address
            hdr_q <= hdrFull[11:0];
            bitCnt_q <= bitCnt_q + 5'h01;
            if (bitCnt_q == 5'h0C) begin
              bitCnt_q <= 5'h00;
              regAddr_q <= hdrFull[4:0];
              isRead_q <= (hdrFull[11:10] == OP_READ);
              if (hdrFull[12] && hdrFull[9:5] == phyAddr_q &&
                  (hdrFull[11:10] == OP_READ ||
                   hdrFull[11:10] == OP_WRITE)) begin
                state_q <= ST_TA;
              end else begin
                state_q <= ST_PRE;
              end
            end
          end
          ST_TA: begin
            // turnaround, reads drive zero in its second bit
            bitCnt_q <= bitCnt_q + 5'h01;
            if (bitCnt_q == 5'h00) begin
              if (isRead_q) begin
                mdioOut <= 1'b0;
                mdioOeN <= 1'b0;
                sh_q <= rdData;
              end
            end else begin
              state_q <= ST_DATA;
              bitCnt_q <= 5'h00;
              if (isRead_q) begin
                mdioOut <= sh_q[15];
                sh_q <= {sh_q[14:0], 1'b0};
              end
            end
          end
          ST_DATA: begin
            // sixteen data bits, msb first
            bitCnt_q <= bitCnt_q + 5'h01;
            if (isRead_q) begin
              mdioOut <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
            end else begin
              sh_q <= {sh_q[14:0], mdioIn};
            end
            if (bitCnt_q == 5'h0F) begin
              state_q <= ST_PRE;
              mdioOut <= 1'b1;
              mdioOeN <= 1'b1;
              if (!isRead_q) begin
                wrEn_q <= 1'b1;
                wrAddr_q <= regAddr_q;
                wrData_q <= {sh_q[14:0], mdioIn};
              end
            end
          end
          default: begin
            state_q <= ST_PRE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seqSoftResetWrite;
    wrEn_q && wrAddr_q == CONTROL_REG_INDEX && wrData_q[15] &&
      !load;
  endsequence
  sequence seqSoftResetDone;
    ctrl_q.softReset ##1 !ctrl_q.softReset;
  endsequence

  AST_SOFT_RESET: assert property (
    seqSoftResetWrite |=> seqSoftResetDone)
    else $error("soft reset bit did not self clear");
  AST_ADV_STRAP: assert property (
    load && anEff |=>
      advert_q[8:5] == advFromStraps($past(straps)))
    else $error("advert bits do not follow straps");
  AST_ADV_DEFAULT: assert property (
    load && !anEff |=> advert_q[8:5] == ADV_DEFAULT)
    else $error("advert bits not default with autoneg off");
  AST_ISO_ZERO: assert property (
    load && straps.phyAddr == 5'h00 |=> ctrl_q.isolate ##1 miiIsolate)
    else $error("zero address did not isolate");
  AST_LED_POL: assert property (
    !load ##1 !load |-> ledOut == ($past(ledIn) ^ ledPol_q))
    else $error("led polarity wrong");
  AST_ADDR_LATCH: assert property (
    load |=> phyAddr_q == $past(straps.phyAddr))
    else $error("phy address not latched");
  AST_OTHER_ADDR: assert property (
    mdcRise && state_q == ST_HDR && bitCnt_q == 5'h0C &&
      hdrFull[9:5] != phyAddr_q |=> state_q == ST_PRE && mdioOeN)
    else $error("frame for another address taken");
  AST_LOOPBACK: assert property (
    wrEn_q && wrAddr_q == CONTROL_REG_INDEX && !load |=>
      ctrl_q.loopback == $past(wrData_q[14]) ##1
      loopback == $past(ctrl_q.loopback))
    else $error("loopback bit not written");
  AST_AN_STRAP: assert property (
    load |=> ctrl_q.anEnable == $past(straps.anEnable))
    else $error("autoneg bit not loaded from strap");
  AST_DUPLEX: assert property (
    load && !straps.anEnable |=>
      ctrl_q.duplex == $past(straps.fullDuplex))
    else $error("duplex bit not from strap");
  AST_SPEED: assert property (
    ctrl_q.anEnable |=> speed100 == $past(anSpeed100))
    else $error("speed bit not ignored under autoneg");
endmodule : psc_strap_regs

// ===== hw/README_none.sv
`timescale 1ns/1ps

// ===== dv/psc_mgmt_host.sv
`timescale 1ns/1ps
// ==========================================
// station manager model on the mdio wire
module psc_mgmt_host
  import psc_pkg::*;
(
  input wire logic ref_clk,
  output logic mdc, // slow clock, still between frames
  output logic mdioIn, // resolved wire level
  input wire logic mdioOut,
  input wire logic mdioOeN,
  output logic rdValid, // one-cycle read done
  output logic [15:0] rdData // last read word
);
  logic hostEn; // host drives the wire
  logic hostVal; // host wire value
  // pull-up wins when nobody drives
  assign mdioIn = hostEn ? hostVal : (mdioOeN ? 1'b1 : mdioOut);
  // idle values at time zero
  initial begin
    mdc = 1'b1;
    hostEn = 1'b0;
    hostVal = 1'b1;
    rdValid = 1'b0;
    rdData = 16'h0000;
  end
  // one bit: three cycles low, rise with a wire sample, four high
  task automatic slot(input logic en, input logic val,
                      output logic smp);
    @(posedge ref_clk);
    #1;
    mdc = 1'b0;
    hostEn = en;
    hostVal = val;
    repeat (3) @(posedge ref_clk);
    #1;
    smp = mdioIn;
    mdc = 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : slot
  // whole frame, fresh preamble, msb first; reads release at ta
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic wr;
    hdr = {2'b01, op, phy, ra};
    wr = (op == OP_WRITE);
    for (int i = 0; i < 32; i++) slot(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) slot(1'b1, hdr[i], s);
    slot(wr, 1'b1, s);
    slot(wr, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      slot(wr, wd[i], s);
      rd[i] = s;
    end
    @(posedge ref_clk);
    #1;
    hostEn = 1'b0;
  endtask : frame
  // read and flag the word for one cycle
  task automatic read(input logic [4:0] phy, input logic [4:0] ra);
    logic [15:0] d;
    frame(OP_READ, phy, ra, 16'h0000, d);
    rdData = d;
    rdValid = 1'b1;
    @(posedge ref_clk);
    #1;
    rdValid = 1'b0;
  endtask : read
  // write one register
  task automatic write(input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd);
    logic [15:0] d;
    frame(OP_WRITE, phy, ra, wd, d);
  endtask : write
endmodule : psc_mgmt_host

// ===== dv/phy_strap_config_and_control_tb.sv
`timescale 1ns/1ps
module phy_strap_config_and_control_tb
  import psc_pkg::*;
;
  logic refClk, rstN, mdc, mdioIn, mdioOut, mdioOeN;
  logic anSpeed100, anFullDuplex, speed100, fullDuplex;
  logic loopback, miiIsolate, rdValid;
  logic [4:0] ledIn, ledOut;
  logic [15:0] rdData;
  psc_strap_s strapsV, st;
  psc_ctrl_s ctrlBits;
  int errCount, nCompared, cycles, seedV;
  logic [15:0] expQ[$]; // pending read results
  string nameQ[$];
  logic [4:0] ra[6]; // read-only places, then vendor ones
  logic [15:0] ev[6];
  logic [15:0] wd;
  // ==========================================
  // clock, design and host
  initial begin
    refClk = 1'b0;
    forever #2.5 refClk = ~refClk;
  end
  psc_strap_regs psc_strap_regs_i (.ref_clk(refClk), .rst_n(rstN),
    .straps(strapsV), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOeN(mdioOeN), .ledIn(ledIn), .ledOut(ledOut),
    .anSpeed100(anSpeed100), .anFullDuplex(anFullDuplex),
    .speed100(speed100), .fullDuplex(fullDuplex), .loopback(loopback),
    .miiIsolate(miiIsolate), .ctrlBits(ctrlBits));
  psc_mgmt_host psc_mgmt_host_i (.ref_clk(refClk), .mdc(mdc),
    .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOeN(mdioOeN),
    .rdValid(rdValid), .rdData(rdData));
  // ==========================================
  // expectations from strap levels
  function automatic logic [15:0] ctrl_exp(psc_strap_s s);
    return {2'b00, s.speed100, s.anEnable, 1'b0, s.phyAddr == 5'h00,
            1'b0, s.anEnable ? 1'b0 : s.fullDuplex, 8'h00};
  endfunction : ctrl_exp
  function automatic logic [15:0] adv_exp(psc_strap_s s);
    if (s.anEnable)
      return {7'h00, s.fastAdvert & s.fullDuplex, s.fastAdvert,
              s.slowAdvert & s.fullDuplex, s.slowAdvert, ADV_SELECTOR};
    return {7'h00, ADV_DEFAULT, ADV_SELECTOR};
  endfunction : adv_exp
  // ==========================================
  // checking and closing
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic closeOut();
    $display("errors %0d compared %0d", errCount, nCompared);
    if (errCount == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : closeOut
  // oldest note meets each finished read
  always @(posedge refClk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        errCount++;
        $display("[ERR] read expected none seen %h", rdData);
      end else begin
        check(nameQ.pop_front(), rdData, expQ.pop_front());
      end
    end
  end
  // hang guard
  always @(posedge refClk) begin
    cycles++;
    if (cycles == 60000) begin
      errCount++;
      closeOut();
    end
  end
  // ==========================================
  // stimulus tasks
  task automatic rd_exp(input string what, input logic [4:0] phy,
                        input logic [4:0] r, input logic [15:0] exp);
    nameQ.push_back(what);
    expQ.push_back(exp);
    psc_mgmt_host_i.read(phy, r);
  endtask : rd_exp
  task automatic wr(input logic [4:0] r, input logic [15:0] d);
    psc_mgmt_host_i.write(st.phyAddr, r, d);
    repeat (4) @(posedge refClk);
    #1;
  endtask : wr
  task automatic do_reset(input psc_strap_s s);
    @(posedge refClk);
    #1;
    rstN = 1'b0;
    strapsV = s;
    repeat (4) @(posedge refClk);
    #1;
    rstN = 1'b1;
    repeat (3) @(posedge refClk);
    #1;
  endtask : do_reset
  // ==========================================
  // main sequence
  initial begin
    rstN = 1'b0;
    strapsV = '0;
    ledIn = 5'h00;
    anSpeed100 = 1'b0;
    anFullDuplex = 1'b0;
    seedV = $urandom(32'h873A);
    for (int i = 0; i < 6; i++) begin
      // random straps, autoneg alternating, first address zero
      st = psc_strap_s'(13'($urandom));
      st.anEnable = i[0];
      st.phyAddr = (i == 0) ? 5'h00 : 5'($urandom_range(31, 1));
      anSpeed100 = 1'($urandom);
      anFullDuplex = 1'($urandom);
      do_reset(st);
      ledIn = 5'($urandom);
      repeat (2) @(posedge refClk);
      #1;
      check("led", {11'h0, ledOut}, {11'h0, ledIn ^ st.phyAddr});
      check("isolate", {15'h0, miiIsolate}, {15'h0, st.phyAddr == 0});
      check("ctrlbits", ctrlBits, ctrl_exp(st));
      rd_exp("ctrl", st.phyAddr, CONTROL_REG_INDEX, ctrl_exp(st));
      rd_exp("adv", st.phyAddr, ADVERT_REG_INDEX, adv_exp(st));
      rd_exp("fast", st.phyAddr, FAST_CTL_REG_INDEX,
        {8'h00, st.nrziEnable, st.code4b5bEnable, 5'h00,
         st.scramblerDisable});
      rd_exp("other", st.phyAddr ^ 5'h01, STATUS_REG_INDEX, 16'hFFFF);
      check("spd", {15'h0, speed100},
        {15'h0, st.anEnable ? anSpeed100 : st.speed100});
      check("dup", {15'h0, fullDuplex},
        {15'h0, st.anEnable ? anFullDuplex : st.fullDuplex});
    end
    // read-only places and an unmapped one, after writes to them
    ra = '{STATUS_REG_INDEX, ID_HIGH_REG_INDEX, ID_LOW_REG_INDEX,
           PARTNER_REG_INDEX, EXPANSION_REG_INDEX, 5'h07};
    ev = '{STATUS_VALUE, ID_HIGH_VALUE, ID_LOW_VALUE, 16'h0000,
           16'h0000, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], 16'($urandom));
      rd_exp("ro", st.phyAddr, ra[i], ev[i]);
    end
    // vendor registers hold what was written
    ra[0] = CFG_IRQ_REG_INDEX;
    ra[1] = IRQ_EN_REG_INDEX;
    ra[2] = MODE_CTL_REG_INDEX;
    for (int i = 0; i < 3; i++) begin
      wd = 16'($urandom);
      wr(ra[i], wd);
      rd_exp("vendor", st.phyAddr, ra[i], wd);
    end
    // a write for another address changes nothing, a refused opcode gets no answer
    psc_mgmt_host_i.write(st.phyAddr ^ 5'h01, MODE_CTL_REG_INDEX, ~wd);
    rd_exp("skip", st.phyAddr, MODE_CTL_REG_INDEX, wd);
    psc_mgmt_host_i.frame(2'h3, st.phyAddr, CONTROL_REG_INDEX,
      16'h0000, wd);
    check("badop", wd, 16'hFFFF);
    // loopback on, autoneg off, 10 half
    wr(CONTROL_REG_INDEX, 16'h4000);
    check("loop", {15'h0, loopback}, 16'h0001);
    check("spd10", {15'h0, speed100}, 16'h0000);
    check("half", {15'h0, fullDuplex}, 16'h0000);
    rd_exp("ctrl_wr", st.phyAddr, CONTROL_REG_INDEX, 16'h4000);
    // autoneg on again: speed bit ignored
    wr(CONTROL_REG_INDEX, 16'h1100);
    check("spd_an", {15'h0, speed100}, {15'h0, anSpeed100});
    check("unloop", {15'h0, loopback}, 16'h0000);
    wr(ADVERT_REG_INDEX, 16'hA1E1);
    rd_exp("adv_wr", st.phyAddr, ADVERT_REG_INDEX, 16'hA1E1);
    // soft reset keeping autoneg, then one clearing it
    wr(CONTROL_REG_INDEX, 16'h9000);
    rd_exp("sr_ctrl", st.phyAddr, CONTROL_REG_INDEX, ctrl_exp(st));
    rd_exp("sr_adv", st.phyAddr, ADVERT_REG_INDEX, adv_exp(st));
    wr(CONTROL_REG_INDEX, 16'h8000);
    rd_exp("sr_def", st.phyAddr, ADVERT_REG_INDEX,
      {7'h00, ADV_DEFAULT, ADV_SELECTOR});
    rd_exp("sr_ctrl2", st.phyAddr, CONTROL_REG_INDEX, ctrl_exp(st));
    repeat (4) @(posedge refClk);
    closeOut();
  end
endmodule : phy_strap_config_and_control_tb
